// *** design/context_shadow.sv ***
`timescale 1ns/1ps
module context_shadow (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic save_i,
    input wire logic restore_i,
    input wire logic [7:0] working_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] bank_i,
    output logic restore_o,
    output logic [7:0] working_o,
    output logic [7:0] status_o,
    output logic [7:0] bank_o
);
    // Single copy: a preempting entry overwrites it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            working_o <= 8'h00;
            status_o <= 8'h00;
            bank_o <= 8'h00;
        end else if (save_i) begin
            working_o <= working_i;
            status_o <= status_i;
            bank_o <= bank_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            restore_o <= 1'b0;
        end else begin
            restore_o <= restore_i;
        end
    end
endmodule

// *** design/irq_source_cell.sv ***
`timescale 1ns/1ps
module irq_source_cell (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic enable_i,
    input wire logic priority_i,
    output logic flag_o,
    output logic high_pend_o,
    output logic low_pend_o
);
    logic flag_q;

    // Flag follows its event regardless of the enable; set beats clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (clr_i) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_o = flag_q;
    assign high_pend_o = flag_q & enable_i & priority_i;
    assign low_pend_o = flag_q & enable_i & ~priority_i;
endmodule

// *** design/prioritized_interrupt_control.sv ***
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - High or unprioritized entry clears the global/high enable.
// - Low priority entry clears the peripheral/low enable instead.
// - The cleared enable blocks same-level preemption of the handler.
// - Every entry copies working, status and bank registers to shadow.
// - High may preempt low; its save overwrites the shadow copy.
// - Low priority entries vector to their own address.
// - Unprioritized and high priority entries share one vector.
// - Fast return restores shadowed registers and re-enables interrupts.
// - Plain return from low handler sets the low enable again.
// - Re-enabled bit depends on level in progress, not on fast.
// - Flags set on events whether or not the source is enabled.
// - Serial port hardware itself sets and clears the flags.
// - Request needs flag, source enable and applicable global enables.
// - Priority mode bit set selects two-level prioritized operation.
// - Mode bit clear: compatibility, global and peripheral both needed.
// - Prioritized: each level needs its own global enable set; the code gates low with both the low and the high enable.
// - Per-source priority bits assign high level, prioritized mode only.
// - Per-source enable bits gate transmit and receive independently.
module prioritized_interrupt_control (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [prio_irq_pkg::ADDR_W-1:0] addr_i,
    input wire logic [prio_irq_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [prio_irq_pkg::DATA_W-1:0] rdata_o,
    input wire logic tx_flag_set_i,
    input wire logic tx_flag_clr_i,
    input wire logic rx_flag_set_i,
    input wire logic rx_flag_clr_i,
    output logic irq_req_o,
    output logic irq_high_o,
    output logic [prio_irq_pkg::VEC_W-1:0] irq_vector_o,
    input wire logic take_i,
    input wire logic ret_i,
    input wire logic fast_i,
    input wire logic [7:0] working_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] bank_i,
    output logic restore_o,
    output logic [7:0] working_o,
    output logic [7:0] status_o,
    output logic [7:0] bank_o,
    output logic irq_o
);
    import prio_irq_pkg::*;

    logic priority_mode_enable_q;
    logic global_high_enable_q;
    logic peripheral_low_enable_q;
    logic [SRC_COUNT-1:0] src_enable_q;
    logic [SRC_COUNT-1:0] src_priority_q;
    logic [SRC_COUNT-1:0] src_flag;
    logic [SRC_COUNT-1:0] src_high_pend;
    logic [SRC_COUNT-1:0] src_low_pend;
    logic [SRC_COUNT-1:0] src_set;
    logic [SRC_COUNT-1:0] src_clr;
    logic [EVT_W-1:0] evt_status_q;
    logic [EVT_W-1:0] evt_mask_q;
    logic [EVT_W-1:0] evt_pulse;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic irq_req_q;
    logic irq_high_q;
    logic [VEC_W-1:0] irq_vector_q;
    logic irq_q;
    logic any_high;
    logic any_low;
    logic any_pend;
    logic high_req;
    logic low_req;
    logic compat_req;
    logic take_ok;
    logic take_high;
    logic take_low;
    logic take_compat;
    logic ret_high;
    logic ret_low;
    logic ret_compat;
    logic ret_any;
    logic wr_irq_ctrl;
    service_state_type svc_q;
    service_state_type svc_d;

    assign src_set[SRC_TX] = tx_flag_set_i;
    assign src_clr[SRC_TX] = tx_flag_clr_i;
    assign src_set[SRC_RX] = rx_flag_set_i;
    assign src_clr[SRC_RX] = rx_flag_clr_i;

    genvar gi;
    generate
        for (gi = 0; gi < SRC_COUNT; gi++) begin : g_src
            irq_source_cell u_cell (
                .mclk_i(mclk_i),
                .srst_i(srst_i),
                .set_i(src_set[gi]),
                .clr_i(src_clr[gi]),
                .enable_i(src_enable_q[gi]),
                .priority_i(src_priority_q[gi]),
                .flag_o(src_flag[gi]),
                .high_pend_o(src_high_pend[gi]),
                .low_pend_o(src_low_pend[gi])
            );
        end
    endgenerate

    // Request qualification per mode
    assign any_high = |src_high_pend;
    assign any_low = |src_low_pend;
    assign any_pend = any_high | any_low;
    assign compat_req = ~priority_mode_enable_q & global_high_enable_q
        & peripheral_low_enable_q & any_pend;
    // Clearing the high enable also masks low level
    assign high_req = priority_mode_enable_q & global_high_enable_q
        & any_high;
    assign low_req = priority_mode_enable_q & global_high_enable_q
        & peripheral_low_enable_q & any_low;

    // Take only what was offered; level comes from the offered request
    assign take_ok = take_i & irq_req_q;
    assign take_compat = take_ok & (svc_q == SVC_IDLE)
        & ~priority_mode_enable_q;
    assign take_high = take_ok & priority_mode_enable_q & irq_high_q;
    assign take_low = take_ok & priority_mode_enable_q & ~irq_high_q;

    // Return classification by level in progress only
    assign ret_high = ret_i & ((svc_q == SVC_HIGH)
        | (svc_q == SVC_HIGH_OVER_LOW));
    assign ret_low = ret_i & (svc_q == SVC_LOW);
    assign ret_compat = ret_i & (svc_q == SVC_COMPAT);
    assign ret_any = ret_high | ret_low | ret_compat;

    always_comb begin
        svc_d = svc_q;
        case (svc_q)
            SVC_IDLE: begin
                if (take_compat) begin
                    svc_d = SVC_COMPAT;
                end else if (take_high) begin
                    svc_d = SVC_HIGH;
                end else if (take_low) begin
                    svc_d = SVC_LOW;
                end
            end
            SVC_COMPAT: begin
                if (ret_i) begin
                    svc_d = SVC_IDLE;
                end
            end
            SVC_LOW: begin
                if (take_high) begin
                    svc_d = SVC_HIGH_OVER_LOW;
                end else if (ret_i) begin
                    svc_d = SVC_IDLE;
                end
            end
            SVC_HIGH: begin
                if (ret_i) begin
                    svc_d = SVC_IDLE;
                end
            end
            SVC_HIGH_OVER_LOW: begin
                if (ret_i) begin
                    svc_d = SVC_LOW;
                end
            end
            default: begin
                svc_d = SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            svc_q <= SVC_IDLE;
        end else begin
            svc_q <= svc_d;
        end
    end

    // Mode and source configuration
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            priority_mode_enable_q <= 1'b0;
        end else if (wr_i && addr_i == ADDR_RESET_CTRL) begin
            priority_mode_enable_q <= wdata_i[PRIO_MODE_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            src_enable_q <= '0;
        end else if (wr_i && addr_i == ADDR_PERIPH_EN) begin
            src_enable_q <= wdata_i[SRC_BASE_BIT +: SRC_COUNT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            src_priority_q <= '0;
        end else if (wr_i && addr_i == ADDR_PERIPH_PRIO) begin
            src_priority_q <= wdata_i[SRC_BASE_BIT +: SRC_COUNT];
        end
    end

    // Hardware entry and return override a software write
    assign wr_irq_ctrl = wr_i & (addr_i == ADDR_IRQ_CTRL);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            global_high_enable_q <= 1'b0;
        end else if (take_high || take_compat) begin
            global_high_enable_q <= 1'b0;
        end else if (ret_high || ret_compat) begin
            global_high_enable_q <= 1'b1;
        end else if (wr_irq_ctrl) begin
            global_high_enable_q <= wdata_i[GLOBAL_HIGH_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            peripheral_low_enable_q <= 1'b0;
        end else if (take_low) begin
            peripheral_low_enable_q <= 1'b0;
        end else if (ret_low) begin
            peripheral_low_enable_q <= 1'b1;
        end else if (wr_irq_ctrl) begin
            peripheral_low_enable_q <= wdata_i[PERIPH_LOW_BIT];
        end
    end

    // Request and vector to the core; dropped in the cycle after a take
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_req_q <= 1'b0;
            irq_high_q <= 1'b0;
            irq_vector_q <= VEC_NONE;
        end else if (take_ok) begin
            irq_req_q <= 1'b0;
            irq_high_q <= 1'b0;
            irq_vector_q <= VEC_NONE;
        end else if (high_req) begin
            irq_req_q <= 1'b1;
            irq_high_q <= 1'b1;
            irq_vector_q <= VEC_HIGH;
        end else if (low_req) begin
            irq_req_q <= 1'b1;
            irq_high_q <= 1'b0;
            irq_vector_q <= VEC_LOW;
        end else if (compat_req) begin
            irq_req_q <= 1'b1;
            irq_high_q <= 1'b0;
            irq_vector_q <= VEC_HIGH;
        end else begin
            irq_req_q <= 1'b0;
            irq_high_q <= 1'b0;
            irq_vector_q <= VEC_NONE;
        end
    end

    context_shadow u_shadow (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .save_i(take_ok),
        .restore_i(ret_any & fast_i),
        .working_i(working_i),
        .status_i(status_i),
        .bank_i(bank_i),
        .restore_o(restore_o),
        .working_o(working_o),
        .status_o(status_o),
        .bank_o(bank_o)
    );

    // Sticky event status, write one to clear, set wins
    assign evt_pulse[EVT_HIGH_ENTRY] = take_high | take_compat;
    assign evt_pulse[EVT_LOW_ENTRY] = take_low;
    assign evt_pulse[EVT_PREEMPT] = take_high & (svc_q == SVC_LOW);
    assign evt_pulse[EVT_RETURN] = ret_any;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            evt_status_q <= EVT_RESET;
        end else if (wr_i && addr_i == ADDR_EVT_STATUS) begin
            evt_status_q <= (evt_status_q & ~wdata_i[EVT_W-1:0]) | evt_pulse;
        end else begin
            evt_status_q <= evt_status_q | evt_pulse;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            evt_mask_q <= EVT_RESET;
        end else if (wr_i && addr_i == ADDR_EVT_MASK) begin
            evt_mask_q <= wdata_i[EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_status_q & evt_mask_q);
        end
    end

    // Read mux; unused and unmapped bits read as zero
    always_comb begin
        rdata_d = REG_RESET;
        case (addr_i)
            ADDR_RESET_CTRL: begin
                rdata_d[PRIO_MODE_BIT] = priority_mode_enable_q;
            end
            ADDR_IRQ_CTRL: begin
                rdata_d[GLOBAL_HIGH_BIT] = global_high_enable_q;
                rdata_d[PERIPH_LOW_BIT] = peripheral_low_enable_q;
            end
            ADDR_PERIPH_EN: begin
                rdata_d[SRC_BASE_BIT +: SRC_COUNT] = src_enable_q;
            end
            ADDR_PERIPH_FLAG: begin
                rdata_d[SRC_BASE_BIT +: SRC_COUNT] = src_flag;
            end
            ADDR_PERIPH_PRIO: begin
                rdata_d[SRC_BASE_BIT +: SRC_COUNT] = src_priority_q;
            end
            ADDR_EVT_STATUS: begin
                rdata_d[EVT_W-1:0] = evt_status_q;
            end
            ADDR_EVT_MASK: begin
                rdata_d[EVT_W-1:0] = evt_mask_q;
            end
            default: begin
                rdata_d = REG_RESET;
            end
        endcase
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_q <= REG_RESET;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= REG_RESET;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_req_o = irq_req_q;
    assign irq_high_o = irq_high_q;
    assign irq_vector_o = irq_vector_q;
    assign irq_o = irq_q;
endmodule

// *** include/prio_irq_pkg.sv ***
package prio_irq_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned VEC_W = 16;
    localparam int unsigned SRC_COUNT = 2;
    localparam int unsigned EVT_W = 4;

    // Register indices on the plain port
    localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_EN = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_FLAG = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_PRIO = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 4'h6;

    // Field positions
    localparam int unsigned PRIO_MODE_BIT = 7;
    localparam int unsigned GLOBAL_HIGH_BIT = 7;
    localparam int unsigned PERIPH_LOW_BIT = 6;
    localparam int unsigned SRC_BASE_BIT = 4;
    localparam int unsigned SRC_TX = 0;
    localparam int unsigned SRC_RX = 1;

    // Event status bits
    localparam int unsigned EVT_HIGH_ENTRY = 0;
    localparam int unsigned EVT_LOW_ENTRY = 1;
    localparam int unsigned EVT_PREEMPT = 2;
    localparam int unsigned EVT_RETURN = 3;

    localparam logic [VEC_W-1:0] VEC_HIGH = 16'h0008;
    localparam logic [VEC_W-1:0] VEC_LOW = 16'h0018;
    localparam logic [VEC_W-1:0] VEC_NONE = 16'h0000;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

    typedef enum logic [4:0] {
        SVC_IDLE = 5'b00001,
        SVC_COMPAT = 5'b00010,
        SVC_LOW = 5'b00100,
        SVC_HIGH = 5'b01000,
        SVC_HIGH_OVER_LOW = 5'b10000
    } service_state_type;
endpackage

// *** verification/core_model.sv ***
`timescale 1ns/1ps
module core_model (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic req_i,
    input wire logic take_en_i,
    output logic take_o,
    output logic [7:0] working_o,
    output logic [7:0] status_o,
    output logic [7:0] bank_o,
    output logic [7:0] seen_o
);
    logic [7:0] ctx_q;
    // Context moves every cycle so a capture one edge off shows up
    always_ff @(posedge mclk_i) begin
        ctx_q <= srst_i ? 8'h00 : ctx_q + 8'h01;
    end
    // One-cycle take pulse, held until the edge that samples it
    always_ff @(posedge mclk_i) begin
        take_o <= !srst_i && take_en_i && req_i && !take_o;
    end
    always_ff @(posedge mclk_i) begin
        seen_o <= srst_i ? 8'h00 : (take_o && req_i) ? ctx_q : seen_o;
    end
    assign working_o = ctx_q;
    assign status_o = ctx_q ^ 8'hFF;
    assign bank_o = ctx_q ^ 8'hA5;
endmodule

// *** verification/irq_props.sv ***
`timescale 1ns/1ps
module irq_props (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [prio_irq_pkg::ADDR_W-1:0] addr_i,
    input wire logic [prio_irq_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic take_i,
    input wire logic ret_i,
    input wire logic fast_i,
    input wire logic irq_req_o,
    input wire logic irq_high_o,
    input wire logic [prio_irq_pkg::VEC_W-1:0] irq_vector_o,
    input wire logic [7:0] working_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] bank_i,
    input wire logic [7:0] working_o,
    input wire logic [7:0] status_o,
    input wire logic [7:0] bank_o,
    input wire logic restore_o
);
    import prio_irq_pkg::*;
    logic mode_q;
    logic took;
    logic [1:0] depth_q;
    assign took = take_i && irq_req_o;
    // Nesting seen from outside; a return with nothing in service is ignored
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            depth_q <= 2'h0;
        end else if (took && depth_q != 2'h2) begin
            depth_q <= depth_q + 2'h1;
        end else if (ret_i && depth_q != 2'h0) begin
            depth_q <= depth_q - 2'h1;
        end
    end
    // Mode shadowed from bus writes; the design hides its register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mode_q <= 1'b0;
        end else if (wr_i && addr_i == ADDR_RESET_CTRL) begin
            mode_q <= wdata_i[PRIO_MODE_BIT];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_vec_high;
        irq_req_o && irq_high_o |-> irq_vector_o == VEC_HIGH;
    endproperty
    a_vec_high: assert property (p_vec_high) else $error("bad vec");
    property p_vec_low;
        irq_req_o && !irq_high_o && mode_q && $past(mode_q)
            |-> irq_vector_o == VEC_LOW;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("bad low vec");
    property p_compat;
        irq_req_o && !mode_q && !$past(mode_q)
            |-> !irq_high_o && irq_vector_o == VEC_HIGH;
    endproperty
    a_compat: assert property (p_compat) else $error("bad compat");
    property p_take_drop;
        took |=> !irq_req_o;
    endproperty
    a_take_drop: assert property (p_take_drop) else $error("req held");
    property p_low_block;
        took && !irq_high_o && mode_q |=> ##1 (!irq_req_o || irq_high_o);
    endproperty
    a_low_block: assert property (p_low_block) else $error("low nest");
    property p_shadow;
        took |=> working_o == $past(working_i) && status_o == $past(status_i)
            && bank_o == $past(bank_i);
    endproperty
    a_shadow: assert property (p_shadow) else $error("no save");
    property p_shadow_hold;
        !took |=> $stable({working_o, status_o, bank_o});
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("moved");
    property p_restore;
        ret_i && fast_i && depth_q != 2'h0 |=> restore_o;
    endproperty
    a_restore: assert property (p_restore) else $error("no restore");
    property p_idle_ret;
        ret_i && depth_q == 2'h0 |=> !restore_o;
    endproperty
    a_idle_ret: assert property (p_idle_ret) else $error("idle ret");
    property p_restore_cause;
        restore_o |-> $past(ret_i && fast_i);
    endproperty
    a_restore_cause: assert property (p_restore_cause) else $error("rst");
endmodule
bind prioritized_interrupt_control irq_props u_props (.mclk_i, .srst_i,
    .addr_i, .wdata_i, .wr_i, .take_i, .ret_i, .fast_i, .irq_req_o,
    .irq_high_o, .irq_vector_o, .working_i, .status_i, .bank_i,
    .working_o, .status_o, .bank_o, .restore_o);

// *** verification/tb_prioritized_interrupt_control.sv ***
`timescale 1ns/1ps
module tb_prioritized_interrupt_control;
    import prio_irq_pkg::*;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ret_i = 1'b0;
    logic fast_i = 1'b0;
    logic take_en = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [DATA_W-1:0] rdata_o;
    logic irq_req_o, irq_high_o, take_i, restore_o, irq_o;
    logic [VEC_W-1:0] irq_vector_o;
    logic [7:0] working_i, status_i, bank_i, working_o, status_o, bank_o;
    logic [7:0] seen;
    int n_fail = 0;
    int n_checks = 0;

    always #5 mclk_i = ~mclk_i;

    prioritized_interrupt_control dut (
        .mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .tx_flag_set_i(ev[0]), .tx_flag_clr_i(ev[1]),
        .rx_flag_set_i(ev[2]), .rx_flag_clr_i(ev[3]),
        .irq_req_o, .irq_high_o, .irq_vector_o, .take_i, .ret_i, .fast_i,
        .working_i, .status_i, .bank_i, .restore_o, .working_o,
        .status_o, .bank_o, .irq_o
    );
    core_model core (
        .mclk_i, .srst_i, .req_i(irq_req_o), .take_en_i(take_en),
        .take_o(take_i), .working_o(working_i), .status_o(status_i),
        .bank_o(bank_i), .seen_o(seen)
    );

    task automatic close_out();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(16'(rdata_o), 16'(e));
    endtask
    task automatic pulse(input logic [3:0] e);
        @(posedge mclk_i);
        ev <= e;
        @(posedge mclk_i);
        ev <= 4'h0;
    endtask
    task automatic req_is(input logic r, input logic h, input logic [15:0] v);
        repeat (2) @(posedge mclk_i);
        #1 chk({14'h0, irq_req_o, irq_high_o}, {14'h0, r, h});
        chk(irq_vector_o, v);
    endtask
    task automatic take_it();
        int i;
        @(posedge mclk_i);
        take_en <= 1'b1;
        for (i = 0; i < 20 && take_i !== 1'b1; i++) @(posedge mclk_i) #1;
        take_en <= 1'b0;
        if (i == 20) begin
            n_fail++;
            close_out();
        end
        repeat (2) @(posedge mclk_i);
        #1;
    endtask
    task automatic ret_it(input logic f);
        @(posedge mclk_i);
        ret_i <= 1'b1;
        fast_i <= f;
        @(posedge mclk_i);
        ret_i <= 1'b0;
        fast_i <= 1'b0;
        #1 chk(16'(restore_o), 16'(f));
    endtask
    task automatic shadow_is();
        chk(16'(working_o), 16'(seen));
        chk(16'(status_o), 16'(seen ^ 8'hFF));
        chk(16'(bank_o), 16'(seen ^ 8'hA5));
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        // Index 7 and 15 are unmapped and must read zero
        for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        pulse(4'b0001);
        rd(ADDR_PERIPH_FLAG, 8'h10);
        pulse(4'b0100);
        wr(ADDR_PERIPH_FLAG, 8'h00);
        rd(ADDR_PERIPH_FLAG, 8'h30);
        pulse(4'b0010);
        rd(ADDR_PERIPH_FLAG, 8'h20);
        pulse(4'b0001);
        req_is(1'b0, 1'b0, VEC_NONE);
        wr(ADDR_IRQ_CTRL, 8'h80);
        wr(ADDR_PERIPH_EN, 8'h10);
        req_is(1'b0, 1'b0, VEC_NONE);
        wr(ADDR_IRQ_CTRL, 8'hC0);
        wr(ADDR_PERIPH_EN, 8'h00);
        req_is(1'b0, 1'b0, VEC_NONE);
        wr(ADDR_PERIPH_EN, 8'h10);
        req_is(1'b1, 1'b0, VEC_HIGH);
        wr(ADDR_EVT_MASK, 8'h0E);
        take_it();
        rd(ADDR_IRQ_CTRL, 8'h40);
        shadow_is();
        wr(ADDR_PERIPH_EN, 8'h30);
        req_is(1'b0, 1'b0, VEC_NONE);
        rd(ADDR_EVT_STATUS, 8'h01);
        chk(16'(irq_o), 16'h0000);
        wr(ADDR_EVT_MASK, 8'h0F);
        rd(ADDR_EVT_MASK, 8'h0F);
        chk(16'(irq_o), 16'h0001);
        wr(ADDR_EVT_STATUS, 8'h01);
        rd(ADDR_EVT_STATUS, 8'h00);
        chk(16'(irq_o), 16'h0000);
        pulse(4'b1010);
        ret_it(1'b1);
        rd(ADDR_IRQ_CTRL, 8'hC0);
        wr(ADDR_RESET_CTRL, 8'h80);
        wr(ADDR_PERIPH_PRIO, 8'h10);
        wr(ADDR_EVT_STATUS, 8'h0F);
        pulse(4'b0100);
        req_is(1'b1, 1'b0, VEC_LOW);
        take_it();
        rd(ADDR_IRQ_CTRL, 8'h80);
        req_is(1'b0, 1'b0, VEC_NONE);
        pulse(4'b0001);
        req_is(1'b1, 1'b1, VEC_HIGH);
        take_it();
        rd(ADDR_IRQ_CTRL, 8'h00);
        shadow_is();
        rd(ADDR_EVT_STATUS, 8'h07);
        pulse(4'b0010);
        ret_it(1'b0);
        rd(ADDR_IRQ_CTRL, 8'h80);
        pulse(4'b1000);
        ret_it(1'b0);
        rd(ADDR_IRQ_CTRL, 8'hC0);
        pulse(4'b0101);
        req_is(1'b1, 1'b1, VEC_HIGH);
        wr(ADDR_PERIPH_PRIO, 8'h00);
        wr(ADDR_IRQ_CTRL, 8'h80);
        req_is(1'b0, 1'b0, VEC_NONE);
        wr(ADDR_IRQ_CTRL, 8'h40);
        req_is(1'b0, 1'b0, VEC_NONE);
        wr(ADDR_PERIPH_PRIO, 8'h30);
        wr(ADDR_RESET_CTRL, 8'h00);
        wr(ADDR_IRQ_CTRL, 8'hC0);
        req_is(1'b1, 1'b0, VEC_HIGH);
        close_out();
    end
endmodule
